/* File: design/rfs_pkg.sv */
/*
 * Package for the receive frame screen and auto-negotiation enable block.
 * Holds the register offsets, the field positions, the reset values, the
 * frame length bounds, the link field widths and the frame tracker states.
 * Assumes a single 50 MHz system clock domain on the register side.
 */
package rfs_pkg;

	// =====================================================================
	// Register map (word offsets on the CPU port)
	// =====================================================================
	localparam logic [7:0]  MISC_CFG_OFS      = 8'h18;
	localparam logic [7:0]  SCREEN_CTL_OFS    = 8'h19;

	// =====================================================================
	// Miscellaneous configuration fields
	// =====================================================================
	localparam int          MISC_CFG_W        = 19;
	localparam logic [18:0] MISC_CFG_RST      = 19'h0_110D;
	localparam int          AUTONEG_RUN_POS   = 5;

	// =====================================================================
	// Receive frame screen control fields
	// =====================================================================
	localparam int          SCREEN_CTL_W      = 6;
	localparam logic [5:0]  SCREEN_CTL_RST    = 6'h00;
	localparam int          BAD_FCS_POS       = 5;
	localparam int          FLOW_CTL_POS      = 4;
	localparam int          TAG_DISCARD_POS   = 3;

	// =====================================================================
	// Frame lengths in bytes
	// =====================================================================
	localparam int          LEN_W             = 14;
	localparam logic [13:0] STD_LEN_MIN       = 14'h0040;
	localparam logic [13:0] STD_LEN_MAX       = 14'h05EE;
	localparam logic [13:0] JUMBO_LEN_MAX     = 14'h2580;

	// =====================================================================
	// Link sampling
	// =====================================================================
	localparam int          LINK_SYNC_W       = LEN_W + 6;
	localparam int          SYNC_STAGES       = 2;

	// =====================================================================
	// Frame tracker
	// =====================================================================
	typedef enum logic [0:0] {
		RFS_IDLE,
		RFS_IN_FRAME
	} rfs_frame_state_t;

endpackage

/* File: design/rfs_screen.sv */
/*
 * Per-port receive frame screen with the auto-negotiation enable bit.
 * Holds the two CPU registers, samples the receive path events from the
 * link clock domain, screens each frame and issues one verdict per frame closed by rx_eof_i,
 * and drives the auto-negotiation engine controls.
 * Assumes the CPU port and the drop-enable bit run on mclk_i, and that the
 * receive path drives its signals on the rising edge of its own clock.
 */
`timescale 1ns/10ps

module rfs_screen (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// CPU register port
	input  wire logic        cpu_wr_i,
	input  wire logic        cpu_rd_i,
	input  wire logic [7:0]  cpu_addr_i,
	input  wire logic [31:0] cpu_wdata_i,
	output logic      [31:0] cpu_rdata_o,
	output logic             cpu_rvalid_o,
	// This port's errored-frame drop enable
	input  wire logic        frame_discard_en_i,
	// Receive path, link clock domain
	input  wire logic        rx_clk_i,
	input  wire logic        rx_sof_i,
	input  wire logic        rx_eof_i,
	input  wire logic        rx_crc_err_i,
	input  wire logic        rx_pause_i,
	input  wire logic        rx_tagged_i,
	input  wire logic [13:0] rx_len_i,
	// Frame verdict towards receive FIFO and system interface
	output logic             verdict_valid_o,
	output logic             verdict_bad_o,
	output logic             verdict_remove_o,
	output logic             verdict_abort_o,
	output logic             removed_inc_o,
	// Auto-negotiation engine controls
	output logic             autoneg_mode_o,
	output logic             autoneg_restart_o
);

	// =====================================================================
	// Register file
	// =====================================================================
	logic [rfs_pkg::MISC_CFG_W-1:0]   misc_cfg_r;
	logic [rfs_pkg::MISC_CFG_W-1:0]   misc_cfg_nxt;
	logic [rfs_pkg::SCREEN_CTL_W-1:0] screen_ctl_r;
	logic [rfs_pkg::SCREEN_CTL_W-1:0] screen_ctl_nxt;
	logic [31:0]                      rdata_r;
	logic [31:0]                      rdata_nxt;
	logic                             rvalid_r;
	logic                             rvalid_nxt;
	logic                             an_mode_r;
	logic                             an_mode_nxt;
	logic                             an_restart_r;
	logic                             an_restart_nxt;
	logic                             an_wr_bit;

	always_comb begin
		misc_cfg_nxt   = misc_cfg_r;
		screen_ctl_nxt = screen_ctl_r;
		rdata_nxt      = rdata_r;
		rvalid_nxt     = 1'b0;
		// Reserved bits are stored as written; software keeps defaults
		if (cpu_wr_i) begin
			case (cpu_addr_i)
				rfs_pkg::MISC_CFG_OFS: begin
					misc_cfg_nxt = cpu_wdata_i[rfs_pkg::MISC_CFG_W-1:0];
				end
				rfs_pkg::SCREEN_CTL_OFS: begin
					screen_ctl_nxt = cpu_wdata_i[rfs_pkg::SCREEN_CTL_W-1:0];
				end
				default: begin
					misc_cfg_nxt = misc_cfg_r;
				end
			endcase
		end
		if (cpu_rd_i) begin
			rvalid_nxt = 1'b1;
			case (cpu_addr_i)
				rfs_pkg::MISC_CFG_OFS: begin
					rdata_nxt = {13'h0000, misc_cfg_r};
				end
				rfs_pkg::SCREEN_CTL_OFS: begin
					rdata_nxt = {26'h000_0000, screen_ctl_r};
				end
				default: begin
					rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			misc_cfg_r   <= rfs_pkg::MISC_CFG_RST;
			screen_ctl_r <= rfs_pkg::SCREEN_CTL_RST;
			rdata_r      <= 32'h0000_0000;
			rvalid_r     <= 1'b0;
		end else begin
			misc_cfg_r   <= misc_cfg_nxt;
			screen_ctl_r <= screen_ctl_nxt;
			rdata_r      <= rdata_nxt;
			rvalid_r     <= rvalid_nxt;
		end
	end

	// =====================================================================
	// Auto-negotiation control
	// =====================================================================
	always_comb begin
		an_wr_bit      = cpu_wdata_i[rfs_pkg::AUTONEG_RUN_POS];
		an_mode_nxt    = an_mode_r;
		an_restart_nxt = 1'b0;
		if (cpu_wr_i && (cpu_addr_i == rfs_pkg::MISC_CFG_OFS)) begin
			an_mode_nxt    = an_wr_bit;
			// Start on every rising write of the run bit
			an_restart_nxt = an_wr_bit & ~an_mode_r;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			an_mode_r    <= 1'b0;
			an_restart_r <= 1'b0;
		end else begin
			an_mode_r    <= an_mode_nxt;
			an_restart_r <= an_restart_nxt;
		end
	end

	// =====================================================================
	// Link sampling
	// =====================================================================
	logic [rfs_pkg::LINK_SYNC_W-1:0] link_meta_r;
	logic [rfs_pkg::LINK_SYNC_W-1:0] link_sync_r;
	logic                            link_clk_prev_r;
	logic                            link_sample;
	logic                            s_sof;
	logic                            s_eof;
	logic                            s_crc;
	logic                            s_pause;
	logic                            s_tagged;
	logic [rfs_pkg::LEN_W-1:0]       s_len;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link_meta_r     <= '0;
			link_sync_r     <= '0;
			link_clk_prev_r <= 1'b0;
		end else begin
			link_meta_r     <= {rx_clk_i, rx_sof_i, rx_eof_i, rx_crc_err_i,
				rx_pause_i, rx_tagged_i, rx_len_i};
			link_sync_r     <= link_meta_r;
			link_clk_prev_r <= link_sync_r[rfs_pkg::LINK_SYNC_W-1];
		end
	end

	// Falling edge of the link clock: data is mid-period and settled
	// Fields cross as one word; they hold a full link period around it
	assign link_sample = link_clk_prev_r
		& ~link_sync_r[rfs_pkg::LINK_SYNC_W-1];
	assign {s_sof, s_eof, s_crc, s_pause, s_tagged, s_len} =
		link_sync_r[rfs_pkg::LINK_SYNC_W-2:0];

	// =====================================================================
	// Frame tracker and screening
	// =====================================================================
	rfs_pkg::rfs_frame_state_t state_r;
	rfs_pkg::rfs_frame_state_t state_nxt;
	logic [2:0] snap_r;
	logic [2:0] snap_nxt;
	logic       snap_den_r;
	logic       snap_den_nxt;
	logic [2:0] use_cfg;
	logic       use_den;
	logic       bad;
	logic       std_len;
	logic       remove;
	logic       v_valid_r;
	logic       v_valid_nxt;
	logic       v_bad_r;
	logic       v_bad_nxt;
	logic       v_remove_r;
	logic       v_remove_nxt;
	logic       v_abort_r;
	logic       v_abort_nxt;
	logic       removed_inc_r;
	logic       removed_inc_nxt;

	always_comb begin
		state_nxt    = state_r;
		snap_nxt     = snap_r;
		snap_den_nxt = snap_den_r;
		v_valid_nxt  = 1'b0;
		v_bad_nxt    = v_bad_r;
		v_remove_nxt = v_remove_r;
		v_abort_nxt  = v_abort_r;
		removed_inc_nxt = 1'b0;
		// Settings live for this frame: fresh ones when it starts now
		if (s_sof) begin
			use_cfg = {screen_ctl_r[rfs_pkg::BAD_FCS_POS],
				screen_ctl_r[rfs_pkg::FLOW_CTL_POS],
				screen_ctl_r[rfs_pkg::TAG_DISCARD_POS]};
			use_den = frame_discard_en_i;
		end else begin
			use_cfg = snap_r;
			use_den = snap_den_r;
		end
		// CRC reject wins whatever the frame type; accept ignores drop enable
		bad = (s_crc & ~use_cfg[2])
			| (s_pause & ~use_cfg[1])
			| (s_tagged & use_cfg[0]);
		std_len = (s_len >= rfs_pkg::STD_LEN_MIN)
			& (s_len <= rfs_pkg::STD_LEN_MAX);
		// Jumbo and out-of-range lengths are never removed, only aborted
		remove = bad & use_den & std_len;
		if (link_sample) begin
			case (state_r)
				rfs_pkg::RFS_IDLE: begin
					if (s_sof) begin
						snap_nxt     = use_cfg;
						snap_den_nxt = use_den;
						state_nxt    = rfs_pkg::RFS_IN_FRAME;
					end
				end
				rfs_pkg::RFS_IN_FRAME: begin
					if (s_sof) begin
						// Restart without end: the newer frame owns the settings
						snap_nxt     = use_cfg;
						snap_den_nxt = use_den;
					end
				end
				default: begin
					state_nxt = rfs_pkg::RFS_IDLE;
				end
			endcase
			if (s_eof && (s_sof || state_r == rfs_pkg::RFS_IN_FRAME)) begin
				state_nxt    = rfs_pkg::RFS_IDLE;
				v_valid_nxt  = 1'b1;
				v_bad_nxt    = bad;
				v_remove_nxt = remove;
				v_abort_nxt  = bad & ~remove;
				removed_inc_nxt = remove;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r    <= rfs_pkg::RFS_IDLE;
			snap_r     <= 3'h0;
			snap_den_r <= 1'b0;
			v_valid_r  <= 1'b0;
			v_bad_r    <= 1'b0;
			v_remove_r <= 1'b0;
			v_abort_r  <= 1'b0;
			removed_inc_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			snap_r     <= snap_nxt;
			snap_den_r <= snap_den_nxt;
			v_valid_r  <= v_valid_nxt;
			v_bad_r    <= v_bad_nxt;
			v_remove_r <= v_remove_nxt;
			v_abort_r  <= v_abort_nxt;
			removed_inc_r <= removed_inc_nxt;
		end
	end

	// =====================================================================
	// Outputs
	// =====================================================================
	assign cpu_rdata_o       = rdata_r;
	assign cpu_rvalid_o      = rvalid_r;
	assign verdict_valid_o   = v_valid_r;
	assign verdict_bad_o     = v_bad_r;
	assign verdict_remove_o  = v_remove_r;
	assign verdict_abort_o   = v_abort_r;
	// Counter increments only for removed, standard-length frames
	assign removed_inc_o     = removed_inc_r;
	assign autoneg_mode_o    = an_mode_r;
	assign autoneg_restart_o = an_restart_r;

endmodule

/* File: sim/rfs_link_model.sv */
/* Receive path model: one frame per call, link clock 160 ns.
   Clock stands still between frames; released lines invert. */
`timescale 1ns/10ps
module rfs_link_model (
	output logic        rx_clk_o,
	output logic        rx_sof_o,
	output logic        rx_eof_o,
	output logic        rx_crc_o,
	output logic        rx_pause_o,
	output logic        rx_tag_o,
	output logic [13:0] rx_len_o
);
	initial begin
		{rx_clk_o, rx_sof_o, rx_eof_o} = 3'h0;
		{rx_crc_o, rx_pause_o, rx_tag_o, rx_len_o} = '0;
	end
	task automatic frame(input logic c, p, t, input logic [13:0] l,
		input int gap);
		rx_clk_o = 1;
		rx_sof_o = 1;
		rx_eof_o = (gap == 0);
		{rx_crc_o, rx_pause_o, rx_tag_o, rx_len_o} = {c, p, t, l};
		#80 rx_clk_o = 0;
		for (int k = 0; k <= gap; k++) begin
			#80 rx_clk_o = 1;
			rx_sof_o = 0;
			rx_eof_o = (k == gap - 1);
			if (k == gap)
				{rx_crc_o, rx_pause_o, rx_tag_o, rx_len_o} = ~{c, p, t, l};
			#80 rx_clk_o = 0;
		end
		#80;
	endtask
endmodule

/* File: sim/rfs_screen_asserts.sv */
/* Port assertions for rfs_screen.
   Bound from the bench top; one clock domain, mclk_i. */
`timescale 1ns/10ps
module rfs_screen_asserts (
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic        cpu_wr_i,
	input wire logic        cpu_rd_i,
	input wire logic [7:0]  cpu_addr_i,
	input wire logic [31:0] cpu_wdata_i,
	input wire logic [31:0] cpu_rdata_o,
	input wire logic        cpu_rvalid_o,
	input wire logic        verdict_valid_o,
	input wire logic        verdict_bad_o,
	input wire logic        verdict_remove_o,
	input wire logic        verdict_abort_o,
	input wire logic        removed_inc_o,
	input wire logic        autoneg_mode_o,
	input wire logic        autoneg_restart_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic an_wr = cpu_wr_i && cpu_addr_i == rfs_pkg::MISC_CFG_OFS;
	wire logic an_b = cpu_wdata_i[rfs_pkg::AUTONEG_RUN_POS];
	// ====
	// CPU port and autoneg
	a_rd_answer: assert property (cpu_rd_i |=> cpu_rvalid_o)
		else $error("read not answered");
	a_rv_cause: assert property (cpu_rvalid_o |-> $past(cpu_rd_i))
		else $error("read valid without read");
	a_rsvd_zero: assert property (cpu_rd_i &&
		cpu_addr_i == rfs_pkg::SCREEN_CTL_OFS |=> cpu_rdata_o[31:6] == 0)
		else $error("reserved screen bits nonzero");
	a_an_on: assert property (an_wr && an_b |=> autoneg_mode_o)
		else $error("autoneg not entered");
	a_an_off: assert property (an_wr && !an_b |=> !autoneg_mode_o)
		else $error("forced mode not entered");
	a_an_fresh: assert property (an_wr && an_b && !autoneg_mode_o
		|=> autoneg_restart_o ##1 !autoneg_restart_o)
		else $error("restart pulse wrong");
	a_rs_cause: assert property (autoneg_restart_o |->
		$rose(autoneg_mode_o)) else $error("restart without enable");
	// ====
	// Frame verdicts
	a_remove_bad: assert property (verdict_valid_o && verdict_remove_o
		|-> verdict_bad_o) else $error("good frame removed");
	a_abort_rest: assert property (verdict_valid_o |->
		verdict_abort_o == (verdict_bad_o && !verdict_remove_o))
		else $error("abort mismatch");
	a_inc_cause: assert property (removed_inc_o |->
		verdict_valid_o && verdict_remove_o) else $error("stray count");
	a_vd_held: assert property (!verdict_valid_o |->
		$stable({verdict_bad_o, verdict_remove_o, verdict_abort_o}))
		else $error("verdict changed between frames");
	a_vd_pulse: assert property (verdict_valid_o |=> !verdict_valid_o)
		else $error("verdict longer than a cycle");
endmodule

/* File: sim/tb.sv */
/* Register and frame screening tests for rfs_screen.
   Needs rfs_pkg, the link model and the checker. */
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
	logic        mclk_i = 0, rst_n_i = 0, cpu_wr_i = 0, cpu_rd_i = 0;
	logic        frame_discard_en_i = 0, cpu_rvalid_o, verdict_valid_o;
	logic        verdict_bad_o, verdict_remove_o, verdict_abort_o;
	logic        removed_inc_o, autoneg_mode_o, autoneg_restart_o;
	logic        rx_clk_i, rx_sof_i, rx_eof_i, rx_crc_err_i;
	logic        rx_pause_i, rx_tagged_i;
	logic [13:0] rx_len_i;
	logic [7:0]  cpu_addr_i = 8'h00;
	logic [31:0] cpu_wdata_i = 32'h0000_0000, cpu_rdata_o;
	int          n_errors = 0, num_checks = 0;
	always #10 mclk_i = ~mclk_i;
	rfs_screen DUT (.*);
	rfs_link_model LNK (.rx_clk_o(rx_clk_i), .rx_sof_o(rx_sof_i),
		.rx_eof_o(rx_eof_i), .rx_crc_o(rx_crc_err_i), .rx_pause_o(rx_pause_i),
		.rx_tag_o(rx_tagged_i), .rx_len_o(rx_len_i));
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk_i);
		{cpu_wr_i, cpu_addr_i, cpu_wdata_i} = {1'b1, a, d};
		@(negedge mclk_i);
		cpu_wr_i = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge mclk_i);
		{cpu_rd_i, cpu_addr_i} = {1'b1, a};
		@(negedge mclk_i);
		cpu_rd_i = 0;
		`CHK({cpu_rvalid_o, cpu_rdata_o}, {1'b1, e})
	endtask
	task automatic frm(input logic [5:0] c, input logic e, cr, p, t,
		input logic [13:0] l, input int gap, input logic [5:0] late);
		logic b, r;
		b = (cr & !c[5]) | (p & !c[4]) | (t & c[3]);
		r = b & e & l >= rfs_pkg::STD_LEN_MIN & l <= rfs_pkg::STD_LEN_MAX;
		wr(rfs_pkg::SCREEN_CTL_OFS, {26'h000_0000, c});
		frame_discard_en_i = e;
		fork
			LNK.frame(cr, p, t, l, gap);
			if (gap > 0) begin
				#200 wr(rfs_pkg::SCREEN_CTL_OFS, {26'h000_0000, late});
				frame_discard_en_i = !e;
			end
			begin
				for (int i = 0; i < 60 && verdict_valid_o !== 1'b1; i++)
					@(posedge mclk_i) #1;
				`CHK({verdict_valid_o, verdict_bad_o, verdict_remove_o,
					verdict_abort_o, removed_inc_o}, {1'b1, b, r, b & !r, r})
			end
		join
		$display("frame test done: ctl %h len %0d", c, l);
	endtask
	initial begin
		#100000;
		n_errors++;
		results();
	end
	initial begin
		repeat (6) @(negedge mclk_i);
		rst_n_i = 1;
		repeat (3) @(negedge mclk_i);
		rd(rfs_pkg::MISC_CFG_OFS, 32'h0000_110D);
		rd(rfs_pkg::SCREEN_CTL_OFS, 32'h0000_0000);
		rd(8'h30, 32'h0000_0000);
		`CHK(autoneg_mode_o, 1'b0)
		wr(rfs_pkg::MISC_CFG_OFS, 32'h0000_112D);
		`CHK({autoneg_mode_o, autoneg_restart_o}, 2'h3)
		wr(rfs_pkg::MISC_CFG_OFS, 32'h0000_112D);
		`CHK({autoneg_mode_o, autoneg_restart_o}, 2'h2)
		wr(rfs_pkg::MISC_CFG_OFS, 32'h0000_110D);
		`CHK({autoneg_mode_o, autoneg_restart_o}, 2'h0)
		wr(rfs_pkg::MISC_CFG_OFS, 32'h0000_112D);
		`CHK({autoneg_mode_o, autoneg_restart_o}, 2'h3)
		rd(rfs_pkg::MISC_CFG_OFS, 32'h0000_112D);
		wr(8'h30, 32'hFFFF_FFFF);
		wr(rfs_pkg::SCREEN_CTL_OFS, 32'hFFFF_FFFF);
		rd(rfs_pkg::SCREEN_CTL_OFS, 32'h0000_003F);
		$display("register test done");
		frm(6'h00, 1, 1, 0, 0, 14'h0064, 0, 6'h00);
		frm(6'h18, 1, 1, 1, 0, 14'h0040, 0, 6'h00);
		frm(6'h20, 1, 1, 0, 0, 14'h0064, 0, 6'h00);
		frm(6'h00, 1, 0, 1, 0, 14'h05EE, 0, 6'h00);
		frm(6'h10, 1, 0, 1, 0, 14'h0064, 0, 6'h00);
		frm(6'h08, 1, 0, 0, 1, 14'h0064, 0, 6'h00);
		frm(6'h00, 1, 0, 0, 1, 14'h0064, 0, 6'h00);
		frm(6'h08, 0, 0, 0, 1, 14'h0064, 0, 6'h00);
		frm(6'h08, 1, 0, 0, 1, 14'h05EF, 0, 6'h00);
		frm(6'h08, 1, 1, 0, 1, 14'h2580, 0, 6'h00);
		frm(6'h00, 1, 1, 0, 0, 14'h003F, 0, 6'h00);
		frm(6'h00, 1, 1, 0, 0, 14'h0064, 3, 6'h20);
		rst_n_i = 0;
		repeat (2) @(negedge mclk_i);
		`CHK({autoneg_mode_o, verdict_bad_o, cpu_rvalid_o}, 3'h0)
		rst_n_i = 1;
		rd(rfs_pkg::MISC_CFG_OFS, 32'h0000_110D);
		rd(rfs_pkg::SCREEN_CTL_OFS, 32'h0000_0000);
		`CHK({autoneg_mode_o, autoneg_restart_o}, 2'h0)
		$display("reset test done");
		results();
	end
endmodule
bind rfs_screen rfs_screen_asserts u_chk (.*);
